// [design/sadc_pkg.sv]
// constants and types shared by the converter control files
package sadc_pkg;

    // register byte addresses on the cpu data bus
    localparam logic [15:0] ADDR_MODE   = 16'hff80;
    localparam logic [15:0] ADDR_CHAN   = 16'hff81;
    localparam logic [15:0] ADDR_RISE   = 16'hff48;
    localparam logic [15:0] ADDR_FALL   = 16'hff49;
    localparam logic [15:0] ADDR_RESULT = 16'hff1e;

    // values after reset
    localparam logic [7:0]  MODE_RST   = 8'h00;
    localparam logic [2:0]  CHAN_RST   = 3'h0;
    localparam logic [3:0]  EDGE_RST   = 4'h0;
    localparam logic [15:0] RESULT_RST = 16'h0000;

    // mode register field positions
    localparam int RUN_BIT   = 7;
    localparam int SRC_BIT   = 6;
    localparam int TIME_HI   = 5;
    localparam int TIME_LO   = 3;
    localparam int EDGE_RISE = 2;
    localparam int EDGE_FALL = 1;
    localparam int BOOST_BIT = 0;
    // pin edge enable position in the rising/falling enable registers
    localparam int PIN_EDGE_BIT = 3;

    // conversion geometry
    localparam int RES_BITS = 10;
    localparam int PAD_BITS = 6;
    localparam logic [RES_BITS-1:0] APPR_MSB = 10'h200;
    localparam logic [PAD_BITS-1:0] PAD_ZERO = 6'h00;
    // one conversion = two sampling steps plus one step per bit
    localparam logic [1:0] SAMPLE_STEPS = 2'h2;
    localparam int STEPS_PER_CONV = 12;

    // conversion times in core clocks, one per allowed time code
    localparam int CONV_CLK_144 = 144;
    localparam int CONV_CLK_120 = 120;
    localparam int CONV_CLK_96  = 96;
    localparam int CONV_CLK_72  = 72;
    localparam int CONV_CLK_60  = 60;
    localparam int CONV_CLK_48  = 48;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_WAIT,
        ST_SAMPLE,
        ST_CONV
    } sadc_state_t;

endpackage

// [design/sadc_approx.sv]
// successive approximation stepper: one comparator decision per step
module sadc_approx
    import sadc_pkg::*;
(
    // clock and reset
    input  wire logic                core_clk,
    input  wire logic                nrst,
    // control from the sequencer and the synchronised comparator
    input  wire logic                clear,
    input  wire logic                step,
    input  wire logic                cmp_high,
    // trial code and end of conversion
    output logic      [RES_BITS-1:0] code,
    output logic                     done
);

    logic [RES_BITS-1:0] mask;

    ////////////////////////////////////////////////////////////////////
    // msb first: keep or drop the bit under trial, then try the next
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            code <= '0;
            mask <= '0;
            done <= 1'b0;
        end else if (clear) begin
            code <= APPR_MSB;
            mask <= APPR_MSB;
            done <= 1'b0;
        end else if (step && mask != '0) begin
            // decision kept, lower bit set as next trial
            code <= (cmp_high ? code : (code & ~mask)) | (mask >> 1);
            mask <= mask >> 1;
            done <= mask[0];
        end else begin
            done <= 1'b0;
        end
    end

endmodule

// [design/sadc_ctrl.sv]
// converter control: registers, start logic, sequencer and result
module sadc_ctrl
    import sadc_pkg::*;
(
    // clock and reset
    input  wire logic                core_clk,
    input  wire logic                nrst,
    // cpu register bus
    input  wire logic [15:0]         bus_addr,
    input  wire logic                bus_wr,
    input  wire logic                bus_bit_wr,
    input  wire logic [2:0]          bus_bit_pos,
    input  wire logic [7:0]          bus_wdata,
    input  wire logic                bus_rd,
    output logic      [15:0]         bus_rdata,
    output logic                     bus_rvalid,
    // trigger pin and comparator from outside
    input  wire logic                external_trigger_pin,
    input  wire logic                cmp_high,
    // analog front end control
    output logic      [2:0]          analog_sel,
    output logic                     sample_en,
    output logic                     hold_en,
    output logic      [RES_BITS-1:0] tap_code,
    output logic                     booster_enable,
    // conversion done request
    output logic                     conversion_done_irq
);

    logic [7:0]          converter_mode_reg;
    logic [2:0]          channel_select_reg;
    logic [3:0]          rising_edge_enable_reg;
    logic [3:0]          falling_edge_enable_reg;
    logic [15:0]         conversion_result_reg;
    sadc_state_t         state;
    logic [4:0]          cnt;
    logic [1:0]          sample_cnt;
    logic [2:0]          trig_sync;
    logic [1:0]          cmp_sync;
    logic [RES_BITS-1:0] appr_code;
    logic                appr_done;
    logic                wr_mode;
    logic                wr_chan;
    logic                cfg_wr;
    logic                tick;
    logic                trig_edge;
    logic                appr_clear;
    logic                appr_step;
    logic                conv_end;
    logic [7:0]          next_mode;
    logic [7:0]          next_rise;
    logic [7:0]          next_fall;

    ////////////////////////////////////////////////////////////////////
    // helpers

    // merge a byte or single-bit write into a stored byte
    function automatic logic [7:0] merge_wr(input logic [7:0] old,
                                            input logic       is_bit,
                                            input logic [2:0] pos,
                                            input logic [7:0] data);
        logic [7:0] res;
        res = data;
        if (is_bit) begin
            res = old;
            res[pos] = data[0];
        end
        return res;
    endfunction

    // clocks per step for a time code; prohibited codes take the slowest
    function automatic logic [4:0] step_len(input logic [2:0] tcode);
        int total;
        total = CONV_CLK_144;
        case (tcode)
            3'h1: total = CONV_CLK_120;
            3'h2: total = CONV_CLK_96;
            3'h4: total = CONV_CLK_72;
            3'h5: total = CONV_CLK_60;
            3'h6: total = CONV_CLK_48;
            default: total = CONV_CLK_144;
        endcase
        return 5'(total / STEPS_PER_CONV);
    endfunction

    // address decode
    function automatic logic hit(input logic [15:0] a,
                                 input logic [15:0] reg_addr);
        return a == reg_addr;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // write strobes; a config write aborts any conversion
    assign wr_mode = (bus_wr | bus_bit_wr) & hit(bus_addr, ADDR_MODE);
    assign wr_chan = bus_wr & hit(bus_addr, ADDR_CHAN);
    assign cfg_wr  = wr_mode | wr_chan;
    assign next_mode = merge_wr(converter_mode_reg, bus_bit_wr,
                                bus_bit_pos, bus_wdata);

    // mode and channel registers
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            converter_mode_reg <= MODE_RST;
            channel_select_reg <= CHAN_RST;
        end else begin
            if (wr_mode) begin
                converter_mode_reg <= next_mode;
            end
            if (wr_chan) begin
                channel_select_reg <= bus_wdata[2:0];
            end
        end
    end

    // merged enable bytes; upper nibble is not stored
    assign next_rise = merge_wr({4'h0, rising_edge_enable_reg}, bus_bit_wr,
                                bus_bit_pos, bus_wdata);
    assign next_fall = merge_wr({4'h0, falling_edge_enable_reg}, bus_bit_wr,
                                bus_bit_pos, bus_wdata);

    // pin edge enable registers, only the trigger pin bit matters here
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rising_edge_enable_reg  <= EDGE_RST;
            falling_edge_enable_reg <= EDGE_RST;
        end else begin
            if ((bus_wr | bus_bit_wr) & hit(bus_addr, ADDR_RISE)) begin
                rising_edge_enable_reg <= next_rise[3:0];
            end
            if ((bus_wr | bus_bit_wr) & hit(bus_addr, ADDR_FALL)) begin
                falling_edge_enable_reg <= next_fall[3:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // read port: answer one cycle after the strobe, unmapped reads zero
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            bus_rdata  <= 16'h0000;
            bus_rvalid <= 1'b0;
        end else begin
            bus_rvalid <= bus_rd;
            bus_rdata  <= 16'h0000;
            if (bus_rd) begin
                case (bus_addr)
                    ADDR_MODE:   bus_rdata <= {8'h00, converter_mode_reg};
                    ADDR_CHAN:   bus_rdata <= {13'h0000, channel_select_reg};
                    ADDR_RISE:   bus_rdata <= {12'h000, rising_edge_enable_reg};
                    ADDR_FALL:   bus_rdata <= {12'h000, falling_edge_enable_reg};
                    ADDR_RESULT: bus_rdata <= conversion_result_reg;
                    default:     bus_rdata <= 16'h0000;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // pin synchronisers; edge detect reads only the settled stages
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            trig_sync <= 3'h0;
            cmp_sync  <= 2'h0;
        end else begin
            trig_sync <= {trig_sync[1:0], external_trigger_pin};
            cmp_sync  <= {cmp_sync[0], cmp_high};
        end
    end

    // mode edge field or pin enable bit selects the valid edge
    assign trig_edge =
        ((converter_mode_reg[EDGE_RISE] |
          rising_edge_enable_reg[PIN_EDGE_BIT]) &
         trig_sync[1] & ~trig_sync[2]) |
        ((converter_mode_reg[EDGE_FALL] |
          falling_edge_enable_reg[PIN_EDGE_BIT]) &
         ~trig_sync[1] & trig_sync[2]);

    ////////////////////////////////////////////////////////////////////
    // step divider: one-cycle enable every step_len clocks
    assign tick = (state == ST_SAMPLE || state == ST_CONV) &&
                  cnt == step_len(converter_mode_reg[TIME_HI:TIME_LO])
                         - 5'h1;

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            cnt <= 5'h0;
        end else if (cfg_wr || tick || state == ST_IDLE ||
                     state == ST_WAIT) begin
            cnt <= 5'h0;
        end else begin
            cnt <= cnt + 5'h1;
        end
    end

    assign appr_clear = state == ST_SAMPLE && tick &&
                        sample_cnt == SAMPLE_STEPS - 2'h1;
    assign appr_step  = state == ST_CONV && tick && !cfg_wr;
    assign conv_end   = state == ST_CONV && appr_done && !cfg_wr;

    ////////////////////////////////////////////////////////////////////
    // sequencer; a config write always wins and restarts from idle
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            state      <= ST_IDLE;
            sample_cnt <= 2'h0;
            sample_en  <= 1'b0;
            hold_en    <= 1'b0;
        end else if (cfg_wr) begin
            state     <= ST_IDLE;
            sample_en <= 1'b0;
            hold_en   <= 1'b0;
        end else begin
            case (state)
                ST_IDLE: begin
                    sample_cnt <= 2'h0;
                    if (converter_mode_reg[RUN_BIT]) begin
                        if (converter_mode_reg[SRC_BIT]) begin
                            state <= ST_WAIT;
                        end else begin
                            state     <= ST_SAMPLE;
                            sample_en <= 1'b1;
                        end
                    end
                end
                ST_WAIT: begin
                    sample_cnt <= 2'h0;
                    if (trig_edge) begin
                        state     <= ST_SAMPLE;
                        sample_en <= 1'b1;
                    end
                end
                ST_SAMPLE: begin
                    if (tick) begin
                        sample_cnt <= sample_cnt + 2'h1;
                    end
                    if (appr_clear) begin
                        state     <= ST_CONV;
                        sample_en <= 1'b0;
                        hold_en   <= 1'b1;
                    end
                end
                ST_CONV: begin
                    sample_cnt <= 2'h0;
                    if (appr_done) begin
                        hold_en <= 1'b0;
                        if (converter_mode_reg[SRC_BIT]) begin
                            state <= ST_WAIT;
                        end else begin
                            state     <= ST_SAMPLE;
                            sample_en <= 1'b1;
                        end
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // approximation register and comparator decisions
    sadc_approx u_approx (
        .core_clk (core_clk),
        .nrst     (nrst),
        .clear    (appr_clear),
        .step     (appr_step),
        .cmp_high (cmp_sync[1]),
        .code     (appr_code),
        .done     (appr_done)
    );

    // result load and done pulse share one edge
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            conversion_result_reg <= RESULT_RST;
            conversion_done_irq   <= 1'b0;
        end else begin
            conversion_done_irq <= conv_end;
            if (conv_end) begin
                // left aligned 10-bit result
                conversion_result_reg <= {appr_code, PAD_ZERO};
            end
        end
    end

    // analog side outputs; tap follows the trial code every step
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            analog_sel     <= CHAN_RST;
            tap_code       <= '0;
            booster_enable <= 1'b0;
        end else begin
            analog_sel     <= channel_select_reg;
            tap_code       <= appr_code;
            booster_enable <= converter_mode_reg[BOOST_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // checks
    AST_RESULT_FROM_APPR: assert property (
        @(posedge core_clk) disable iff (!nrst)
        conversion_done_irq |->
            conversion_result_reg == {$past(appr_code), PAD_ZERO})
        else $error("result does not match finished approximation");

    AST_RESULT_LOW_ZERO: assert property (
        @(posedge core_clk) disable iff (!nrst)
        conversion_result_reg[PAD_BITS-1:0] == PAD_ZERO)
        else $error("result low bits not zero");

    AST_RESULT_ONLY_AT_END: assert property (
        @(posedge core_clk) disable iff (!nrst)
        $changed(conversion_result_reg) |-> conversion_done_irq)
        else $error("result changed without done pulse");

    AST_IRQ_ONE_CYCLE: assert property (
        @(posedge core_clk) disable iff (!nrst)
        conversion_done_irq |=> !conversion_done_irq)
        else $error("done pulse longer than one cycle");

    AST_HW_STOPS: assert property (
        @(posedge core_clk) disable iff (!nrst)
        conversion_done_irq && converter_mode_reg[SRC_BIT] |->
            state == ST_WAIT)
        else $error("hardware start did not stop after conversion");

    AST_SW_REPEATS: assert property (
        @(posedge core_clk) disable iff (!nrst)
        conversion_done_irq && !converter_mode_reg[SRC_BIT] |->
            state == ST_SAMPLE && sample_en)
        else $error("software start did not repeat");

    AST_ABORT_RESTART: assert property (
        @(posedge core_clk) disable iff (!nrst)
        cfg_wr ##1 !cfg_wr && converter_mode_reg[RUN_BIT] |->
            state == ST_IDLE ##1 state != ST_IDLE)
        else $error("config write did not abort and restart");

    AST_STOPPED_STAYS: assert property (
        @(posedge core_clk) disable iff (!nrst)
        state == ST_IDLE && !converter_mode_reg[RUN_BIT] |=>
            state == ST_IDLE)
        else $error("conversion left idle while stopped");

    AST_TRIG_STARTS: assert property (
        @(posedge core_clk) disable iff (!nrst)
        state == ST_WAIT && trig_edge && !cfg_wr |=> state == ST_SAMPLE)
        else $error("trigger edge did not start conversion");

    AST_MSB_FIRST: assert property (
        @(posedge core_clk) disable iff (!nrst)
        appr_clear && !cfg_wr |=> appr_code == APPR_MSB)
        else $error("approximation did not start at msb");

    COV_HW_DONE: cover property (
        @(posedge core_clk) disable iff (!nrst)
        conversion_done_irq && converter_mode_reg[SRC_BIT]);

    COV_SW_DONE: cover property (
        @(posedge core_clk) disable iff (!nrst)
        conversion_done_irq && !converter_mode_reg[SRC_BIT]);

    COV_ABORT: cover property (
        @(posedge core_clk) disable iff (!nrst)
        state == ST_CONV && cfg_wr);

endmodule

// [testbench/sadc_front.sv]
// comparator, tap string and sample-hold as seen by the converter control
module sadc_front
    import sadc_pkg::*;
(
    // clock
    input  wire logic                     core_clk,
    // analog level of each channel, set by the bench
    input  wire logic [7:0][RES_BITS-1:0] level,
    // front end control from the block
    input  wire logic [2:0]               analog_sel,
    input  wire logic                     sample_en,
    input  wire logic                     hold_en,
    input  wire logic [RES_BITS-1:0]      tap_code,
    // comparator decision
    output logic                          cmp_high
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [RES_BITS-1:0] held     = '0;
    logic                idle_bit = 1'b0;

    // held level follows the selected input only while sampling
    always_ff @(posedge core_clk) begin
        if (sample_en) begin
            held <= level[analog_sel];
        end
        idle_bit <= ~idle_bit;
    end

    // no digital read of the shared input pins is modelled
    // outside hold the decision means nothing, so it toggles every cycle
    assign cmp_high = hold_en ? (held >= tap_code) : idle_bit;
endmodule

// [testbench/sar_adc_control_tb.sv]
// self-checking bench for the converter control block
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin \
    n_mismatch++; $display("unexpected %s exp %h got %h", n, e, g); end end
module sar_adc_control_tb
    import sadc_pkg::*;
    ();
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct packed {
        logic [2:0]  ch;
        logic [2:0]  tc;
        logic [9:0]  v;
        logic [15:0] exp;
    } sadc_row_t;

    // stimulus and observed ports
    logic        core_clk = 0, nrst = 0, bus_wr = 0, bus_bit_wr = 0;
    logic        bus_rd = 0, pin = 0;
    logic [15:0] bus_addr = '0;
    logic [2:0]  bus_bit_pos = '0;
    logic [7:0]  bus_wdata = '0;
    logic [7:0][9:0] lvl = '0;
    logic [15:0] bus_rdata, d;
    logic        bus_rvalid, cmp_high, sample_en, hold_en, boost, irq;
    logic [2:0]  analog_sel;
    logic [9:0]  tap_code;
    int          n_mismatch = 0, comparisons = 0, cyc = 0, n, k, len;
    // ordinary cases: every time code, every channel, edge codes
    sadc_row_t rows [8] = '{'{0, 0, 10'h3ff, 16'hffc0},
        '{1, 1, 10'h000, 16'h0000}, '{2, 2, 10'h200, 16'h8000},
        '{3, 4, 10'h1ff, 16'h7fc0}, '{4, 5, 10'h155, 16'h5540},
        '{5, 6, 10'h2aa, 16'haa80}, '{6, 7, 10'h001, 16'h0040},
        '{7, 3, 10'h3fe, 16'hff80}};

    sadc_ctrl DUT (.core_clk(core_clk), .nrst(nrst), .bus_addr(bus_addr),
        .bus_wr(bus_wr), .bus_bit_wr(bus_bit_wr), .bus_bit_pos(bus_bit_pos),
        .bus_wdata(bus_wdata), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
        .bus_rvalid(bus_rvalid), .external_trigger_pin(pin),
        .cmp_high(cmp_high), .analog_sel(analog_sel),
        .sample_en(sample_en), .hold_en(hold_en), .tap_code(tap_code),
        .booster_enable(boost), .conversion_done_irq(irq));
    sadc_front front (.core_clk(core_clk), .level(lvl),
        .analog_sel(analog_sel), .sample_en(sample_en), .hold_en(hold_en),
        .tap_code(tap_code), .cmp_high(cmp_high));

    always #10 core_clk = ~core_clk;

    // a full run takes far less than the ceiling, which only cuts a hang short
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            summarize();
        end
    end

    function automatic int step_len(logic [2:0] t);
        case (t)
            3'h1: return CONV_CLK_120 / 12;
            3'h2: return CONV_CLK_96 / 12;
            3'h4: return CONV_CLK_72 / 12;
            3'h5: return CONV_CLK_60 / 12;
            3'h6: return CONV_CLK_48 / 12;
            default: return CONV_CLK_144 / 12;
        endcase
    endfunction

    // strobes are one-cycle pulses launched on the falling edge
    task automatic wr(input logic [15:0] a, input logic [7:0] v);
        @(negedge core_clk);
        bus_addr = a;
        bus_wdata = v;
        bus_wr = 1;
        @(negedge core_clk);
        bus_wr = 0;
    endtask
    task automatic bitwr(input logic [15:0] a, input logic [2:0] p,
                         input logic v);
        @(negedge core_clk);
        bus_addr = a;
        bus_bit_pos = p;
        bus_wdata = {7'h00, v};
        bus_bit_wr = 1;
        @(negedge core_clk);
        bus_bit_wr = 0;
    endtask
    task automatic rd(input logic [15:0] a, output logic [15:0] v);
        @(negedge core_clk);
        bus_addr = a;
        bus_rd = 1;
        @(negedge core_clk);
        bus_rd = 0;
        for (int i = 0; i < 3 && bus_rvalid !== 1'b1; i++) @(negedge core_clk);
        `CHK("rvalid", 1'b1, bus_rvalid)
        v = bus_rdata;
    endtask
    task automatic wait_irq(input int lim, output int c);
        c = 0;
        while (irq !== 1'b1 && c < lim) begin
            @(negedge core_clk);
            c++;
        end
    endtask
    task automatic count_irq(input int c, output int m);
        m = 0;
        repeat (c) begin
            @(negedge core_clk);
            if (irq === 1'b1) m++;
        end
    endtask
    task automatic summarize();
        $display("counts: %0d compared, %0d mismatched", comparisons,
                 n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    initial begin
        repeat (8) @(negedge core_clk);
        nrst = 1;
        rd(ADDR_MODE, d); `CHK("mode rst", 16'h0000, d)
        rd(ADDR_CHAN, d); `CHK("chan rst", 16'h0000, d)
        rd(ADDR_RESULT, d); `CHK("result rst", 16'h0000, d)
        rd(16'hff00, d); `CHK("unmapped", 16'h0000, d)
        $display("test reset done");
        // software start, back to back conversions on each row
        foreach (rows[i]) begin
            len = step_len(rows[i].tc);
            lvl[rows[i].ch] = rows[i].v;
            wr(ADDR_CHAN, {5'h00, rows[i].ch});
            wr(ADDR_MODE, {2'b10, rows[i].tc, 3'h0});
            `CHK("sel", rows[i].ch, analog_sel)
            wait_irq(400, n);
            `CHK("resample", 1'b1, sample_en)
            `CHK("hold off", 1'b0, hold_en)
            @(negedge core_clk);
            `CHK("irq width", 1'b0, irq)
            wait_irq(400, n);
            `CHK("period", 1'b1, n + 1 >= 12 * len && n < 12 * len + 6)
            rd(ADDR_RESULT, d); `CHK("result", rows[i].exp, d)
            rd(ADDR_MODE, d); `CHK("mode", {8'h00, 2'b10, rows[i].tc, 3'h0}, d)
        end
        wr(ADDR_MODE, 8'h00);
        count_irq(300, k); `CHK("stopped", 0, k)
        $display("test software start done");
        // hardware start with each edge code, time code 110
        for (int e = 0; e < 4; e++) begin
            wr(ADDR_MODE, {5'b11110, e[1:0], 1'b1});
            count_irq(20, k); `CHK("standby", 0, k)
            pin = 1;
            count_irq(100, k); `CHK("rise", e[1], k)
            pin = 0;
            count_irq(100, k); `CHK("fall", e[0], k)
        end
        `CHK("booster", 1'b1, boost)
        wr(ADDR_RISE, 8'h08);
        wr(ADDR_MODE, 8'hf1);
        pin = 1;
        count_irq(100, k); `CHK("pin rise", 1, k)
        pin = 0;
        count_irq(100, k); `CHK("pin fall", 0, k)
        $display("test hardware start done");
        // a channel write mid-conversion restarts it from the beginning
        wr(ADDR_MODE, 8'h80);
        count_irq(60, k);
        wr(ADDR_CHAN, 8'h00);
        wait_irq(400, n);
        `CHK("abort", 1'b1, k == 0 && n >= 140 && n <= 160)
        bitwr(ADDR_MODE, 3'h7, 1'b0);
        bitwr(ADDR_MODE, 3'h0, 1'b1);
        rd(ADDR_MODE, d); `CHK("bit write", 16'h0001, d)
        count_irq(300, k); `CHK("bit stop", 0, k)
        $display("test abort and bit write done");
        // reset in mid-run clears a nonzero result
        rd(ADDR_RESULT, d); `CHK("before rst", 16'hffc0, d)
        wr(ADDR_MODE, 8'h80);
        nrst = 0;
        repeat (2) @(negedge core_clk);
        nrst = 1;
        rd(ADDR_RESULT, d); `CHK("result rst2", 16'h0000, d)
        rd(ADDR_MODE, d); `CHK("mode rst2", 16'h0000, d)
        $display("test mid-run reset done");
        summarize();
    end
endmodule
